//--- pbc_coltest.sv
// pbc_coltest: collision test echo of transmit enable onto the collision signal
// assumes tx_en_s is already synchronised; latency is three cycles from the pin
`timescale 1ns/1ps
`default_nettype none

module pbc_coltest (
	input wire logic clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic blocked,
	input wire logic tx_en_s,
	output logic col
);
	import pbc_pkg::*;

	typedef struct packed {
		logic col;
	} pbc_col_t;

	pbc_col_t r_reg;
	pbc_col_t r_next;

	always_comb
	begin
		r_next.col = enable & ~blocked & tx_en_s;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r_reg <= '0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign col = r_reg.col;
endmodule // pbc_coltest

`default_nettype wire

//--- pbc_mgmt_model.sv
// pbc_mgmt_model: station manager driving management frames
// assumes mdio has a pull-up; mdc stands low outside frames
`timescale 1ns/1ps
`default_nettype none

module pbc_mgmt_model (
	input wire logic clk,
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe
);
	logic m_oe = 1'b0;
	logic m_d = 1'b0;

	// wire level: device, then manager, else pull-up
	assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_d : 1'b1);
	initial mdc = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// one mdc period: data set while low, sampled just before the rise
	task automatic bit_cyc(input logic oe, input logic d, output logic smp);
		m_oe = oe;
		m_d = d;
		repeat (8) @(posedge clk);
		#1;
		smp = mdio_in;
		mdc = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		mdc = 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		hdr = {32'hFFFFFFFF, 2'b01, op, pa, ra};
		rd = 16'h0000;
		for (int i = 45; i >= 0; i--)
			bit_cyc(1'b1, hdr[i], s);
		for (int i = 0; i < 18; i++)
		begin
			if (op == 2'b01)
				bit_cyc(1'b1, (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : wd[17 - i], s);
			else
			begin
				bit_cyc(1'b0, 1'b0, s);
				if (i >= 2)
					rd[17 - i] = s;
			end
		end
		m_oe = 1'b0;
	endtask
endmodule // pbc_mgmt_model

`default_nettype wire

//--- pbc_pkg.sv
// pbc_pkg: constants, states and state record of the basic control/status register block
// assumes a 125 MHz clock and a management station on the serial management pins
package pbc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int BIT_TIME_NS = 10;
	localparam int COL_ON_BITS = 512;
	localparam int COL_OFF_BITS = 4;
	localparam int COL_ON_NS = COL_ON_BITS * BIT_TIME_NS;
	localparam int COL_OFF_NS = COL_OFF_BITS * BIT_TIME_NS;
	localparam int COL_ON_CYC = COL_ON_NS / CLK_PERIOD_NS;
	localparam int COL_OFF_CYC = COL_OFF_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam int CB_RESET = 15;
	localparam int CB_LOOPBACK = 14;
	localparam int CB_SPEED = 13;
	localparam int CB_AN_EN = 12;
	localparam int CB_PWR_DN = 11;
	localparam int CB_ISOLATE = 10;
	localparam int CB_RESTART = 9;
	localparam int CB_DUPLEX = 8;
	localparam int CB_COLL_TEST = 7;
	localparam logic [6:0] CTRL_RSVD_VAL = 7'h00;
	localparam logic [3:0] STAT_CAP_HI = 4'hF;
	localparam logic [3:0] STAT_RSVD_VAL = 4'h0;
	localparam logic [15:0] RDATA_NONE = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// management frame
	localparam logic [5:0] PRE_ONES = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] DATA_LAST = 5'h11;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam int SYNC_W = 13;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR = 3'b001,
		ST_RD = 3'b010,
		ST_WR = 3'b011
	} pbc_st_t;

	typedef struct packed {
		pbc_st_t st;
		logic [4:0] cnt;
		logic [5:0] ones;
		logic pre_ok;
		logic [15:0] sh;
		logic mine;
		logic [4:0] reg_a;
		logic mdc_d;
		logic mdio_out;
		logic mdio_oe;
		logic [1:0] strap_cnt;
		logic strap_pend;
		logic loopback;
		logic speed_sel;
		logic an_en;
		logic pwr_dn;
		logic isolate;
		logic restart;
		logic duplex_sel;
		logic coll_test;
		logic link_ll;
		logic pd_eff;
		logic speed_100;
		logic full_duplex;
	} pbc_state_t;

endpackage

//--- pbc_properties.sv
// pbc_properties: port-level assertions for pbc_regs
// assumes it is bound into pbc_regs with a 125 MHz clock
`timescale 1ns/1ps
`default_nettype none

module pbc_properties (
	input wire logic clk,
	input wire logic srst,
	input wire logic fiber_mode_enable,
	input wire logic power_down_interrupt_pin_n,
	input wire logic tx_en,
	input wire logic col,
	input wire logic an_started,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic an_enable,
	input wire logic an_restart,
	input wire logic power_down,
	input wire logic speed_100,
	input wire logic full_duplex
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////////
	a_fiber_kills_an: assert property (fiber_mode_enable [*6] |-> !an_enable)
		else $error("negotiation enabled in fiber mode");
	a_an_mode_follow: assert property ($past(an_enable) && an_enable |->
		speed_100 == $past(an_speed_100) && full_duplex == $past(an_full_duplex))
		else $error("speed or duplex not from negotiation");
	a_pin_powers_down: assert property (!power_down_interrupt_pin_n [*6] |-> power_down)
		else $error("power-down pin ignored");
	a_col_from_tx: assert property (col |-> $past(tx_en, 2) || $past(tx_en, 3) || $past(tx_en, 4))
		else $error("collision without transmit enable");
	a_col_drops: assert property (!tx_en [*5] |-> !col)
		else $error("collision held after transmit enable fell");
	a_restart_needs_an: assert property ($rose(an_restart) |-> an_enable)
		else $error("restart set with negotiation off");
	a_restart_clears: assert property (an_restart && an_started |=> !an_restart)
		else $error("restart not cleared on start");
	a_restart_holds: assert property (an_restart && !an_started && !fiber_mode_enable |=> an_restart)
		else $error("restart dropped before start");
endmodule // pbc_properties

`default_nettype wire

//--- pbc_regs.sv
// pbc_regs: basic control and status registers behind the serial management pins
// assumes mdc well below the clock rate; engine and media logic on the same clock
//
// How it works
// - fiber mode enable forces auto-negotiation enable to zero.
// - with auto-negotiation on, speed and duplex bits are ignored.
// - with auto-negotiation off, speed and duplex come from control bits 13 and 8.
// - control bit 11 powers the transceiver down; registers keep working.
// - effective power-down is the bit ORed with the power-down pin.
// - power-down pin low sets the power-down bit.
// - control bit 10 isolates the port from the MII, management stays alive.
// - writing 1 to bit 9 restarts negotiation only when bit 12 is 1.
// - restart bit reads 1 until negotiation starts, then clears itself.
// - writing 0 to the restart bit does not disturb negotiation.
// - bit 8 picks full or half duplex; reset value from a strap.
// - collision test asserts collision within 512 bit times of transmit enable.
// - collision test drops collision within 4 bit times of transmit enable falling.
// - control bits 6:0 ignore writes and read zero.
// - status bits 14 and 13 always read one.
// - status bit 12 always reads one.
// - bit 13 picks 100 or 10 Mb/s when negotiation is off.
// - auto-negotiation enable loads from its strap at reset.
`timescale 1ns/1ps
`default_nettype none

module pbc_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr_strap,
	input wire logic an_enable_strap,
	input wire logic duplex_strap,
	input wire logic speed_strap,
	input wire logic fiber_mode_enable,
	input wire logic power_down_interrupt_pin_n,
	input wire logic tx_en,
	output logic col,
	input wire logic an_started,
	input wire logic an_done,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic link_up,
	output logic an_enable,
	output logic an_restart,
	output logic power_down,
	output logic isolate,
	output logic loopback,
	output logic speed_100,
	output logic full_duplex
);
	import pbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic s_mdc;
	logic s_mdio;
	logic s_pd_n;
	logic s_tx_en;
	logic s_fx;
	logic s_an_strap;
	logic s_dup_strap;
	logic s_spd_strap;
	logic [4:0] s_addr;

	// power-down pin enters inverted so the cleared synchroniser reads as idle after reset
	assign pins_raw = {phy_addr_strap, speed_strap, duplex_strap, an_enable_strap,
		fiber_mode_enable, tx_en, ~power_down_interrupt_pin_n, mdio_in, mdc};

	pbc_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.d(pins_raw),
		.q(pins_s)
	);

	assign s_mdc = pins_s[0];
	assign s_mdio = pins_s[1];
	assign s_pd_n = ~pins_s[2];
	assign s_tx_en = pins_s[3];
	assign s_fx = pins_s[4];
	assign s_an_strap = pins_s[5];
	assign s_dup_strap = pins_s[6];
	assign s_spd_strap = pins_s[7];
	assign s_addr = pins_s[12:8];

	////////////////////////////////////////////////////////////////////////////
	// state
	pbc_state_t r_reg;
	pbc_state_t r_next;
	logic mdc_rise;
	logic [15:0] ctrl_rd;
	logic [15:0] stat_rd;
	logic [15:0] wd;
	logic wr_ok;

	assign mdc_rise = s_mdc & ~r_reg.mdc_d;

	// control register as read back
	assign ctrl_rd = {1'b0, r_reg.loopback, r_reg.speed_sel, r_reg.an_en, r_reg.pwr_dn,
		r_reg.isolate, r_reg.restart, r_reg.duplex_sel, r_reg.coll_test, CTRL_RSVD_VAL};

	// status register: fixed abilities plus live bits
	assign stat_rd = {1'b0, STAT_CAP_HI, STAT_RSVD_VAL, 1'b1, an_done, 1'b0, 1'b1, r_reg.link_ll,
		1'b0, 1'b1};

	assign wd = {r_reg.sh[14:0], s_mdio};
	// a write lands only when addressed here and aimed at the control register
	assign wr_ok = r_reg.mine & (r_reg.reg_a == REG_CONTROL);

	always_comb
	begin
		r_next = r_reg;
		r_next.mdc_d = s_mdc;

		////////////////////////////////////////////////////////////////////////
		// management frame engine
		if (mdc_rise)
		begin
			case (r_reg.st)
				ST_IDLE:
				begin
					if (s_mdio)
					begin
						if (r_reg.ones != PRE_ONES)
						begin
							r_next.ones = r_reg.ones + 6'h01;
						end
					end
					else
					begin
						if ((r_reg.ones == PRE_ONES) || (r_reg.pre_ok && (r_reg.ones != 6'h00)))
						begin
							r_next.st = ST_HDR;
							r_next.cnt = 5'h00;
						end
						r_next.ones = 6'h00;
					end
				end
				ST_HDR:
				begin
					r_next.sh = {r_reg.sh[14:0], s_mdio};
					r_next.cnt = r_reg.cnt + 5'h01;
					if (r_reg.cnt == HDR_LAST)
					begin
						r_next.cnt = 5'h00;
						r_next.reg_a = r_next.sh[4:0];
						r_next.mine = (r_next.sh[9:5] == s_addr);
						if (!r_next.sh[12] || ((r_next.sh[11:10] != OP_READ) && (r_next.sh[11:10] != OP_WRITE)))
						begin
							r_next.pre_ok = 1'b0;
							r_next.st = ST_IDLE;
						end
						else if (r_next.sh[11:10] == OP_READ)
						begin
							r_next.st = ST_RD;
						end
						else
						begin
							r_next.st = ST_WR;
						end
					end
				end
				ST_RD:
				begin
					r_next.cnt = r_reg.cnt + 5'h01;
					if (r_reg.cnt == 5'h00)
					begin
						r_next.mdio_oe = r_reg.mine;
						r_next.mdio_out = 1'b0;
						if (r_reg.reg_a == REG_CONTROL)
						begin
							r_next.sh = ctrl_rd;
						end
						else if (r_reg.reg_a == REG_STATUS)
						begin
							r_next.sh = stat_rd;
						end
						else
						begin
							r_next.sh = RDATA_NONE;
						end
						if (r_reg.mine && (r_reg.reg_a == REG_STATUS))
						begin
							r_next.link_ll = link_up;
						end
					end
					else if (r_reg.cnt == DATA_LAST)
					begin
						r_next.mdio_oe = 1'b0;
						r_next.mdio_out = 1'b0;
						r_next.pre_ok = 1'b1;
						r_next.st = ST_IDLE;
					end
					else
					begin
						r_next.mdio_out = r_reg.sh[15];
						r_next.sh = {r_reg.sh[14:0], 1'b0};
					end
				end
				ST_WR:
				begin
					r_next.sh = wd;
					r_next.cnt = r_reg.cnt + 5'h01;
					// a turnaround other than 1,0 drops the frame and asks for a full preamble again
					if ((r_reg.cnt == 5'h01) && (wd[1:0] != TA_WRITE))
					begin
						r_next.st = ST_IDLE;
						r_next.pre_ok = 1'b0;
						r_next.ones = 6'h00;
						r_next.cnt = 5'h00;
					end
					else if (r_reg.cnt == DATA_LAST)
					begin
						r_next.st = ST_IDLE;
						r_next.pre_ok = 1'b1;
					end
				end
				default:
				begin
					r_next.st = ST_IDLE;
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// control register updates
		if (an_started)
		begin
			r_next.restart = 1'b0;
		end

		// writes to the status address or a foreign address fall through untouched
		if (mdc_rise && (r_reg.st == ST_WR) && (r_reg.cnt == DATA_LAST)
			&& wr_ok)
		begin
			if (r_next.sh[CB_RESET])
			begin
				r_next.loopback = 1'b0;
				r_next.pwr_dn = 1'b0;
				r_next.isolate = 1'b0;
				r_next.restart = 1'b0;
				r_next.coll_test = 1'b0;
				r_next.strap_pend = 1'b1;
				r_next.strap_cnt = 2'h0;
			end
			else
			begin
				r_next.loopback = r_next.sh[CB_LOOPBACK];
				r_next.speed_sel = r_next.sh[CB_SPEED];
				r_next.an_en = r_next.sh[CB_AN_EN];
				r_next.pwr_dn = r_next.sh[CB_PWR_DN];
				r_next.isolate = r_next.sh[CB_ISOLATE];
				r_next.duplex_sel = r_next.sh[CB_DUPLEX];
				r_next.coll_test = r_next.sh[CB_COLL_TEST];
				if (r_next.sh[CB_RESTART] && r_next.sh[CB_AN_EN])
				begin
					r_next.restart = 1'b1;
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// strap capture after reset release
		if (r_reg.strap_pend)
		begin
			r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
			if (r_reg.strap_cnt == STRAP_WAIT)
			begin
				r_next.strap_pend = 1'b0;
				r_next.an_en = s_an_strap;
				r_next.duplex_sel = s_dup_strap;
				r_next.speed_sel = s_spd_strap;
			end
		end

		if (!s_pd_n)
		begin
			r_next.pwr_dn = 1'b1;
		end
		if (s_fx)
		begin
			r_next.an_en = 1'b0;
			r_next.restart = 1'b0;
		end
		if (!link_up)
		begin
			r_next.link_ll = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////
		// registered effective outputs
		r_next.pd_eff = r_next.pwr_dn | ~s_pd_n;
		r_next.speed_100 = r_next.an_en ? an_speed_100 : r_next.speed_sel;
		r_next.full_duplex = r_next.an_en ? an_full_duplex : r_next.duplex_sel;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.strap_pend <= 1'b1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// collision test
	pbc_coltest u_col (
		.clk(clk),
		.srst(srst),
		.enable(r_reg.coll_test),
		.blocked(r_reg.isolate | r_reg.pd_eff),
		.tx_en_s(s_tx_en),
		.col(col)
	);

	assign mdio_out = r_reg.mdio_out;
	assign mdio_oe = r_reg.mdio_oe;
	assign an_enable = r_reg.an_en;
	assign an_restart = r_reg.restart;
	assign power_down = r_reg.pd_eff;
	assign isolate = r_reg.isolate;
	assign loopback = r_reg.loopback;
	assign speed_100 = r_reg.speed_100;
	assign full_duplex = r_reg.full_duplex;
endmodule // pbc_regs

`default_nettype wire

//--- pbc_regs_test.sv
// pbc_regs_test: directed register and pin tests for pbc_regs
// assumes pbc_mgmt_model as station manager, device address 1
`timescale 1ns/1ps
`default_nettype none

module pbc_regs_test;
	import pbc_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic mdc, mdio_in, mdio_out, mdio_oe, col, an_enable, an_restart, power_down, isolate;
	logic speed_100, full_duplex, loopback;
	logic fiber_mode_enable = 1'b0;
	logic power_down_interrupt_pin_n = 1'b1;
	logic tx_en = 1'b0;
	logic an_started = 1'b0;
	logic an_done = 1'b0;
	logic an_speed_100 = 1'b0;
	logic an_full_duplex = 1'b0;
	int n_errors = 0;
	int cmp_count = 0;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	pbc_regs dut_u (.clk, .srst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr_strap(5'h01),
		.an_enable_strap(1'b1), .duplex_strap(1'b1), .speed_strap(1'b1), .fiber_mode_enable,
		.power_down_interrupt_pin_n, .tx_en, .col, .an_started, .an_done, .an_speed_100,
		.an_full_duplex, .link_up(1'b0), .an_enable, .an_restart, .power_down, .isolate,
		.loopback, .speed_100, .full_duplex);
	pbc_mgmt_model mgmt_u (.clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

	////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] v;
		mgmt_u.frame(OP_WRITE, 5'h01, ra, d, v);
		cyc(6);
	endtask

	task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] v;
		mgmt_u.frame(OP_READ, 5'h01, ra, 16'h0000, v);
		chk(v, exp);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(50_000 * CLK_PERIOD_NS);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial
	begin
		cyc(2);
		srst = 1'b0;
		cyc(10);
		rdc(REG_STATUS, 16'h7849);
		wr(REG_STATUS, 16'h0000);
		an_done = 1'b1;
		rdc(REG_STATUS, 16'h7869);
		rdc(REG_CONTROL, 16'h3100);
		chk({14'h0000, an_enable, speed_100 | full_duplex}, 16'h0002);
		an_speed_100 = 1'b1;
		cyc(2);
		chk({14'h0000, speed_100, full_duplex}, 16'h0002);
		$display("test status and straps done");
		for (int k = 0; k < 4; k++)
		begin
			wr(REG_CONTROL, {2'b00, k[1], 4'h0, k[0], 8'h7F});
			rdc(REG_CONTROL, {2'b00, k[1], 4'h0, k[0], 8'h00});
			chk({14'h0000, speed_100, full_duplex}, 16'(k));
		end
		$display("test forced mode done");
		wr(REG_CONTROL, 16'h0200);
		rdc(REG_CONTROL, 16'h0000);
		wr(REG_CONTROL, 16'h1200);
		rdc(REG_CONTROL, 16'h1200);
		wr(REG_CONTROL, 16'h1000);
		chk(16'(an_restart), 16'h0001);
		an_started = 1'b1;
		cyc(1);
		an_started = 1'b0;
		cyc(2);
		rdc(REG_CONTROL, 16'h1000);
		$display("test restart done");
		wr(REG_CONTROL, 16'h0080);
		tx_en = 1'b1;
		cyc(6);
		chk(16'(col), 16'h0001);
		tx_en = 1'b0;
		cyc(COL_OFF_CYC);
		chk(16'(col), 16'h0000);
		wr(REG_CONTROL, 16'h0480);
		tx_en = 1'b1;
		cyc(6);
		chk({14'h0000, col, isolate}, 16'h0001);
		tx_en = 1'b0;
		rdc(REG_CONTROL, 16'h0480);
		$display("test collision and isolate done");
		wr(REG_CONTROL, 16'h0800);
		chk(16'(power_down), 16'h0001);
		wr(REG_CONTROL, 16'h0000);
		chk(16'(power_down), 16'h0000);
		power_down_interrupt_pin_n = 1'b0;
		cyc(8);
		chk(16'(power_down), 16'h0001);
		power_down_interrupt_pin_n = 1'b1;
		rdc(REG_CONTROL, 16'h0800);
		fiber_mode_enable = 1'b1;
		wr(REG_CONTROL, 16'h1000);
		rdc(REG_CONTROL, 16'h0000);
		chk(16'(an_enable), 16'h0000);
		$display("test power-down and fiber done");
		wr(REG_CONTROL, 16'h4800);
		chk({14'h0000, loopback, power_down}, 16'h0003);
		wr(REG_CONTROL, 16'h8000);
		chk({14'h0000, loopback, power_down}, 16'h0000);
		rdc(REG_CONTROL, 16'h2100);
		$display("test software reset done");
		end_of_test();
	end
endmodule // pbc_regs_test

bind pbc_regs pbc_properties chk_u (.clk, .srst, .fiber_mode_enable, .power_down_interrupt_pin_n,
	.tx_en, .col, .an_started, .an_speed_100, .an_full_duplex, .an_enable, .an_restart,
	.power_down, .speed_100, .full_duplex);

`default_nettype wire

//--- pbc_sync.sv
// pbc_sync: two-stage synchroniser for a group of slow pins
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pbc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pbc_sync_t;

	pbc_sync_t r_reg;
	pbc_sync_t r_next;

	always_comb
	begin
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r_reg <= '0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;
endmodule // pbc_sync

`default_nettype wire
